// [common/dtf_cfg.svh]
/*
 * Constants for the disk task file front end: register selects,
 * field positions, command codes, timing figures.
 * Assumes a single 100 MHz system clock.
 */
`ifndef DTF_CFG_SVH
`define DTF_CFG_SVH

`define DTF_CLK_NS 10
// register selects on the 3-bit address
`define DTF_SEL_DATA 3'h0
`define DTF_SEL_ERR_PRECOMP 3'h1
`define DTF_SEL_SDH 3'h6
`define DTF_SEL_STAT_CMD 3'h7
// status bits
`define DTF_ST_BUSY 7
`define DTF_ST_READY 6
`define DTF_ST_WFAULT 5
`define DTF_ST_SEEKDONE 4
`define DTF_ST_DREQ 3
`define DTF_ST_CORR 2
`define DTF_ST_ERR 0
// error bits
`define DTF_ER_BADBLK 7
`define DTF_ER_UNCORR 6
`define DTF_ER_IDCRC 5
`define DTF_ER_IDNF 4
`define DTF_ER_ABORT 2
`define DTF_ER_TRK0 1
`define DTF_ER_NOMARK 0
// command opcode fields
`define DTF_OP_RESTORE 4'h1
`define DTF_OP_SEEK 4'h7
`define DTF_OP_READ 4'h2
`define DTF_OP_WRITE 5'h06
`define DTF_OP_FORMAT 8'h50
// timing
`define DTF_STEP_MIN_US 35
`define DTF_STEP_UNIT_US 500
`define DTF_PRECOMP_NS 12
`define DTF_MARK_WINDOW 16
`define DTF_RESTORE_STEPS 1024
`define DTF_LONG_EXTRA 4
`define DTF_SDH_ECC 7
`define DTF_RESET_ERR 8'h00

`endif

// [common/dtf_pkg.sv]
/*
 * Types shared by both ends of the task file link.
 * Assumes dtf_cfg.svh for numeric constants.
 */
package dtf_pkg;
   typedef enum logic [2:0] {
      DTF_IDLE = 3'b000,
      DTF_CHECK = 3'b001,
      DTF_STEP = 3'b010,
      DTF_MEDIA = 3'b011,
      DTF_XFER = 3'b100,
      DTF_DONE = 3'b101
   } dtf_state_t;
   typedef enum logic [2:0] {
      DTF_C_NONE = 3'b000,
      DTF_C_RESTORE = 3'b001,
      DTF_C_SEEK = 3'b010,
      DTF_C_READ = 3'b011,
      DTF_C_WRITE = 3'b100,
      DTF_C_FORMAT = 3'b101
   } dtf_cmd_t;
endpackage : dtf_pkg

// [common/dtf_if.sv]
/*
 * Parallel task file bus between host and controller.
 * Assumes both ends clocked by the same clk_sys.
 */
`timescale 1ns/1ps
interface dtf_if;
   logic [2:0] addr;
   logic rd_strobe;
   logic wr_strobe;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic data_request_line;
   logic interrupt_request_line;
   modport device (
      input addr, rd_strobe, wr_strobe, wdata,
      output rdata, data_request_line, interrupt_request_line
   );
   modport host (
      output addr, rd_strobe, wr_strobe, wdata,
      input rdata, data_request_line, interrupt_request_line
   );
endinterface : dtf_if

// [core/dtf_device.sv]
/*
 * Controller end: task file decode, status and fault flags, command
 * interpreter, sector buffer port, precomp zone, step timing.
 * Assumes a drive-side media engine reporting outcomes as one-cycle
 * pulses and synchronous drive lines for the selected drive.
 */
`timescale 1ns/1ps
`include "dtf_cfg.svh"
module dtf_device
   import dtf_pkg::*;
#(
   parameter int SECTOR_BYTES = 256,
   parameter int STEP_MIN_CYC = (`DTF_STEP_MIN_US * 1000) / `DTF_CLK_NS,
   parameter int STEP_UNIT_CYC = (`DTF_STEP_UNIT_US * 1000) / `DTF_CLK_NS
) (
   input wire logic clk_sys,
   input wire logic reset,
   dtf_if.device bus,
   input wire logic drive_ready,
   input wire logic drive_write_fault,
   input wire logic drive_seek_done,
   input wire logic track_zero_line,
   input wire logic [9:0] target_cylinder,
   input wire logic media_id_found,
   input wire logic media_id_missing,
   input wire logic media_id_crc_bad,
   input wire logic media_bad_block,
   input wire logic media_mark_seen,
   input wire logic media_byte_tick,
   input wire logic media_data_ok,
   input wire logic media_data_corrected,
   input wire logic media_data_uncorrectable,
   output logic reduced_write_current_line,
   output logic precomp_enable,
   output logic [3:0] precomp_delay_ns,
   output logic step_pulse,
   output logic write_enable
);
   localparam int CNT_W = 20;
   localparam int BUF_BYTES = SECTOR_BYTES + `DTF_LONG_EXTRA;
   localparam int PTR_W = $clog2(BUF_BYTES + 1);

   logic [7:0] precomp_start_cylinder_reg;
   logic [7:0] sdh_reg;
   logic [7:0] fault_flags_reg;
   logic [7:0] fault_flags_next;
   logic busy_reg;
   logic corrected_reg;
   logic dreq_reg;
   logic irq_reg;
   logic [3:0] step_rate_code_reg;
   logic [7:0] cmd_reg;
   dtf_cmd_t cmd_kind;
   dtf_state_t state_reg;
   logic [CNT_W-1:0] step_cnt_reg;
   logic [10:0] steps_done_reg;
   logic [4:0] mark_cnt_reg;
   logic [PTR_W-1:0] ptr_reg;
   logic [7:0] sector_mem [BUF_BYTES];
   logic [7:0] status_byte;
   logic [CNT_W-1:0] step_period;
   logic [PTR_W-1:0] xfer_len;
   logic cmd_wr, stat_rd, data_rd, data_wr, drive_bad, step_tick;

   assign cmd_wr = bus.wr_strobe && bus.addr == `DTF_SEL_STAT_CMD && !busy_reg;
   assign stat_rd = bus.rd_strobe && bus.addr == `DTF_SEL_STAT_CMD;
   // strobes outside a transfer are ignored, protecting the buffer
   assign data_rd = bus.rd_strobe && bus.addr == `DTF_SEL_DATA && dreq_reg;
   assign data_wr = bus.wr_strobe && bus.addr == `DTF_SEL_DATA && dreq_reg;
   assign drive_bad = !drive_ready || !drive_seek_done || drive_write_fault;

   always_comb begin
      cmd_kind = DTF_C_NONE;
      if (cmd_reg[7:4] == `DTF_OP_RESTORE) cmd_kind = DTF_C_RESTORE;
      else if (cmd_reg[7:4] == `DTF_OP_SEEK) cmd_kind = DTF_C_SEEK;
      else if (cmd_reg[7:4] == `DTF_OP_READ && !cmd_reg[0]) cmd_kind = DTF_C_READ;
      else if (cmd_reg[7:3] == `DTF_OP_WRITE && !cmd_reg[0]) cmd_kind = DTF_C_WRITE;
      else if (cmd_reg == `DTF_OP_FORMAT) cmd_kind = DTF_C_FORMAT;
   end

   // code 0 is the fast step, others n half-milliseconds
   assign step_period = (step_rate_code_reg == 4'h0) ? CNT_W'(STEP_MIN_CYC)
      : CNT_W'(STEP_UNIT_CYC * step_rate_code_reg);
   // long only honoured with ecc selected in sdh
   assign xfer_len = (cmd_reg[1] && sdh_reg[`DTF_SDH_ECC]) ? PTR_W'(BUF_BYTES)
      : PTR_W'(SECTOR_BYTES);
   assign step_tick = step_cnt_reg == CNT_W'(1);

   always_comb begin
      status_byte = 8'h00;
      status_byte[`DTF_ST_BUSY] = busy_reg;
      status_byte[`DTF_ST_READY] = drive_ready;
      status_byte[`DTF_ST_WFAULT] = drive_write_fault;
      status_byte[`DTF_ST_SEEKDONE] = drive_seek_done;
      status_byte[`DTF_ST_DREQ] = dreq_reg;
      status_byte[`DTF_ST_CORR] = corrected_reg;
      status_byte[`DTF_ST_ERR] = |fault_flags_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         precomp_start_cylinder_reg <= 8'h00;
         sdh_reg <= 8'h00;
      end else if (bus.wr_strobe && !busy_reg) begin
         if (bus.addr == `DTF_SEL_ERR_PRECOMP) precomp_start_cylinder_reg <= bus.wdata;
         if (bus.addr == `DTF_SEL_SDH) sdh_reg <= bus.wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_reg <= 8'h00;
         step_rate_code_reg <= 4'h0;
      end else if (cmd_wr) begin
         cmd_reg <= bus.wdata;
         if (bus.wdata[7:4] == `DTF_OP_RESTORE || bus.wdata[7:4] == `DTF_OP_SEEK)
            step_rate_code_reg <= bus.wdata[3:0];
      end
   end

   // zone compare widened so register times four cannot wrap
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reduced_write_current_line <= 1'b0;
         precomp_enable <= 1'b0;
         precomp_delay_ns <= 4'h0;
      end else begin
         reduced_write_current_line <=
            target_cylinder >= {precomp_start_cylinder_reg, 2'b00};
         precomp_enable <= target_cylinder >= {precomp_start_cylinder_reg, 2'b00};
         precomp_delay_ns <= 4'(`DTF_PRECOMP_NS);
      end
   end

   always_comb begin
      fault_flags_next = fault_flags_reg;
      if (state_reg == DTF_CHECK && drive_bad)
         fault_flags_next[`DTF_ER_ABORT] = 1'b1;
      if (state_reg == DTF_STEP && step_tick && !track_zero_line
          && steps_done_reg == 11'(`DTF_RESTORE_STEPS) && cmd_kind == DTF_C_RESTORE)
         fault_flags_next[`DTF_ER_TRK0] = 1'b1;
      if (state_reg == DTF_MEDIA) begin
         if (media_id_missing) fault_flags_next[`DTF_ER_IDNF] = 1'b1;
         if (media_id_crc_bad) fault_flags_next[`DTF_ER_IDCRC] = 1'b1;
         if (media_bad_block) fault_flags_next[`DTF_ER_BADBLK] = 1'b1;
         if (media_data_uncorrectable) fault_flags_next[`DTF_ER_UNCORR] = 1'b1;
         if (cmd_kind == DTF_C_READ && mark_cnt_reg == 5'(`DTF_MARK_WINDOW)
             && !media_mark_seen)
            fault_flags_next[`DTF_ER_NOMARK] = 1'b1;
      end
      if (cmd_wr) fault_flags_next = `DTF_RESET_ERR;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) fault_flags_reg <= `DTF_RESET_ERR;
      else fault_flags_reg <= fault_flags_next;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) corrected_reg <= 1'b0;
      else if (cmd_wr) corrected_reg <= 1'b0;
      else if (state_reg == DTF_MEDIA && media_data_corrected) corrected_reg <= 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= DTF_IDLE;
         busy_reg <= 1'b0;
         dreq_reg <= 1'b0;
         step_cnt_reg <= '0;
         steps_done_reg <= 11'h000;
         mark_cnt_reg <= 5'h00;
         ptr_reg <= '0;
         step_pulse <= 1'b0;
         write_enable <= 1'b0;
      end else begin
         step_pulse <= 1'b0;
         write_enable <= 1'b0;
         case (state_reg)
            DTF_IDLE: begin
               if (cmd_wr) begin
                  busy_reg <= 1'b1;
                  state_reg <= DTF_CHECK;
               end
            end
            DTF_CHECK: begin
               steps_done_reg <= 11'h000;
               step_cnt_reg <= step_period;
               mark_cnt_reg <= 5'h00;
               ptr_reg <= '0;
               if (drive_bad || cmd_kind == DTF_C_NONE) state_reg <= DTF_DONE;
               else if (cmd_kind == DTF_C_RESTORE) state_reg <= DTF_STEP;
               else if (cmd_kind == DTF_C_WRITE) begin
                  busy_reg <= 1'b0;
                  dreq_reg <= 1'b1;
                  state_reg <= DTF_XFER;
               end else state_reg <= DTF_MEDIA;
            end
            DTF_STEP: begin
               if (track_zero_line) state_reg <= DTF_DONE;
               else if (step_tick) begin
                  if (steps_done_reg == 11'(`DTF_RESTORE_STEPS)) state_reg <= DTF_DONE;
                  else begin
                     step_pulse <= 1'b1;
                     steps_done_reg <= steps_done_reg + 11'h001;
                     step_cnt_reg <= step_period;
                  end
               end else step_cnt_reg <= step_cnt_reg - CNT_W'(1);
            end
            DTF_MEDIA: begin
               if (media_id_found) mark_cnt_reg <= 5'h01;
               else if (media_byte_tick && mark_cnt_reg != 5'h00
                        && mark_cnt_reg != 5'(`DTF_MARK_WINDOW))
                  mark_cnt_reg <= mark_cnt_reg + 5'h01;
               if (media_id_missing || media_id_crc_bad || media_bad_block
                   || media_data_uncorrectable
                   || (cmd_kind == DTF_C_READ && mark_cnt_reg == 5'(`DTF_MARK_WINDOW)
                       && !media_mark_seen))
                  state_reg <= DTF_DONE;
               else if (cmd_kind == DTF_C_READ && (media_data_ok || media_data_corrected)) begin
                  busy_reg <= 1'b0;
                  dreq_reg <= 1'b1;
                  state_reg <= DTF_XFER;
               end else if (cmd_kind != DTF_C_READ && media_data_ok) begin
                  write_enable <= cmd_kind == DTF_C_WRITE;
                  state_reg <= DTF_DONE;
               end
            end
            DTF_XFER: begin
               if ((data_rd || data_wr) && ptr_reg == xfer_len - PTR_W'(1)) begin
                  dreq_reg <= 1'b0;
                  if (cmd_kind == DTF_C_WRITE) begin
                     busy_reg <= 1'b1;
                     state_reg <= DTF_MEDIA;
                  end else state_reg <= DTF_IDLE;
               end
               if (data_rd || data_wr) ptr_reg <= ptr_reg + PTR_W'(1);
            end
            DTF_DONE: begin
               busy_reg <= 1'b0;
               state_reg <= DTF_IDLE;
            end
            default: state_reg <= DTF_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (data_wr) sector_mem[ptr_reg] <= bus.wdata;
   end

   // raise wins over the clearing access in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) irq_reg <= 1'b0;
      else if ((state_reg == DTF_DONE)
               || (state_reg == DTF_MEDIA && cmd_kind == DTF_C_READ && !cmd_reg[3]
                   && (media_data_ok || media_data_corrected)
                   && !media_data_uncorrectable && !media_id_missing
                   && !media_id_crc_bad && !media_bad_block)
               || (state_reg == DTF_XFER && data_rd && cmd_reg[3]
                   && ptr_reg == xfer_len - PTR_W'(1)))
         irq_reg <= 1'b1;
      else if (cmd_wr || stat_rd) irq_reg <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) bus.rdata <= 8'h00;
      else if (bus.addr == `DTF_SEL_STAT_CMD) bus.rdata <= status_byte;
      else if (bus.addr == `DTF_SEL_ERR_PRECOMP) bus.rdata <= fault_flags_reg;
      else if (bus.addr == `DTF_SEL_SDH) bus.rdata <= sdh_reg;
      else if (bus.addr == `DTF_SEL_DATA && dreq_reg) bus.rdata <= sector_mem[ptr_reg];
      else bus.rdata <= 8'h00;
   end

   assign bus.data_request_line = dreq_reg;
   assign bus.interrupt_request_line = irq_reg;
endmodule : dtf_device

// [core/dtf_host.sv]
/*
 * Host end: loads precomp and sdh, writes a command, moves sector
 * bytes through the data port while data request is up.
 * Assumes the controller answers with rdata one cycle after address.
 */
`timescale 1ns/1ps
`include "dtf_cfg.svh"
module dtf_host
   import dtf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   dtf_if.host bus,
   input wire logic start,
   input wire logic [7:0] cmd_in,
   input wire logic [7:0] precomp_in,
   input wire logic [7:0] sdh_in,
   input wire logic [7:0] wr_byte,
   output logic wr_byte_take,
   output logic [7:0] rd_byte,
   output logic rd_byte_valid,
   output logic [7:0] status_seen,
   output logic done,
   output logic idle
);
   typedef enum logic [2:0] {
      DTF_H_IDLE = 3'b000,
      DTF_H_PRE = 3'b001,
      DTF_H_SDH = 3'b010,
      DTF_H_CMD = 3'b011,
      DTF_H_WAIT = 3'b100,
      DTF_H_DATA = 3'b101,
      DTF_H_STAT = 3'b110
   } dtf_host_state_t;
   dtf_host_state_t state_reg;
   logic [7:0] cmd_reg;
   logic is_read, rd_pend_reg;

   assign is_read = cmd_reg[7:4] == `DTF_OP_READ;
   assign idle = state_reg == DTF_H_IDLE;
   assign wr_byte_take = state_reg == DTF_H_DATA && bus.data_request_line && !is_read;

   always_comb begin
      bus.addr = `DTF_SEL_STAT_CMD;
      bus.rd_strobe = 1'b0;
      bus.wr_strobe = 1'b0;
      bus.wdata = 8'h00;
      case (state_reg)
         DTF_H_PRE: begin
            bus.addr = `DTF_SEL_ERR_PRECOMP;
            bus.wr_strobe = 1'b1;
            bus.wdata = precomp_in;
         end
         DTF_H_SDH: begin
            bus.addr = `DTF_SEL_SDH;
            bus.wr_strobe = 1'b1;
            bus.wdata = sdh_in;
         end
         DTF_H_CMD: begin
            bus.wr_strobe = 1'b1;
            bus.wdata = cmd_reg;
         end
         DTF_H_DATA: begin
            bus.addr = `DTF_SEL_DATA;
            // data port touched only while request is up
            bus.rd_strobe = bus.data_request_line && is_read;
            bus.wr_strobe = bus.data_request_line && !is_read;
            bus.wdata = wr_byte;
         end
         DTF_H_STAT: bus.rd_strobe = 1'b1;
         default: bus.addr = `DTF_SEL_STAT_CMD;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= DTF_H_IDLE;
         cmd_reg <= 8'h00;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_reg)
            DTF_H_IDLE: if (start) begin
               cmd_reg <= cmd_in;
               state_reg <= DTF_H_PRE;
            end
            DTF_H_PRE: state_reg <= DTF_H_SDH;
            DTF_H_SDH: state_reg <= DTF_H_CMD;
            DTF_H_CMD: state_reg <= DTF_H_WAIT;
            DTF_H_WAIT: if (bus.data_request_line) state_reg <= DTF_H_DATA;
               // request checked first: a pio read raises both lines together
               else if (bus.interrupt_request_line) state_reg <= DTF_H_STAT;
            DTF_H_DATA: if (!bus.data_request_line) state_reg <= DTF_H_WAIT;
            DTF_H_STAT: begin
               done <= 1'b1;
               state_reg <= DTF_H_IDLE;
            end
            default: state_reg <= DTF_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_pend_reg <= 1'b0;
         rd_byte <= 8'h00;
         rd_byte_valid <= 1'b0;
         status_seen <= 8'h00;
      end else begin
         rd_pend_reg <= bus.rd_strobe && bus.addr == `DTF_SEL_DATA;
         rd_byte_valid <= rd_pend_reg;
         if (rd_pend_reg) rd_byte <= bus.rdata;
         if (state_reg == DTF_H_STAT) status_seen <= 8'h00;
         else if (done) status_seen <= bus.rdata;
      end
   end
endmodule : dtf_host

// [bench/dtf_props.sv]
/* checker on the task file bus joining host end and device end.
   assumes status/command at select 7, faults at 1, data port at 0. */
`timescale 1ns/1ps
module dtf_props (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [2:0] addr,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic data_request_line,
   input wire logic interrupt_request_line
);
   default clocking dcb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [7:0] cmd_reg;
   logic rd_cmd;
   // last command byte; writes while busy are not filtered, host never sends them
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_reg <= 8'h00;
      end else if (wr_strobe && addr == 3'h7) begin
         cmd_reg <= wdata;
      end
   end
   assign rd_cmd = cmd_reg[7:4] == 4'h2;
   property p_stat_clr;
      rd_strobe && addr == 3'h7 |=> !interrupt_request_line;
   endproperty
   a_stat_clr: assert property (p_stat_clr) else $error("irq kept after status read");
   property p_cmd_clr;
      wr_strobe && addr == 3'h7 |=> !interrupt_request_line;
   endproperty
   a_cmd_clr: assert property (p_cmd_clr) else $error("irq kept after command");
   property p_dreq_stat;
      rd_strobe && addr == 3'h7 ##1 !rdata[7] |-> rdata[3] == $past(data_request_line);
   endproperty
   a_dreq_stat: assert property (p_dreq_stat) else $error("status bit 3 differs from dreq");
   property p_stat_gap;
      addr == 3'h7 |=> rdata[1] == 1'b0;
   endproperty
   a_stat_gap: assert property (p_stat_gap) else $error("status bit 1 not zero");
   property p_err_gap;
      addr == 3'h1 |=> rdata[3] == 1'b0;
   endproperty
   a_err_gap: assert property (p_err_gap) else $error("fault bit 3 not zero");
   property p_dreq_fall;
      $fell(data_request_line) |-> $past(addr) == 3'h0 && $past(rd_strobe || wr_strobe);
   endproperty
   a_dreq_fall: assert property (p_dreq_fall) else $error("dreq fell without data access");
   property p_pio_irq;
      rd_cmd && !cmd_reg[3] && $rose(data_request_line) |-> interrupt_request_line;
   endproperty
   a_pio_irq: assert property (p_pio_irq) else $error("pio read irq not before dreq");
   property p_dma_irq;
      rd_cmd && cmd_reg[3] && $rose(interrupt_request_line) |-> $fell(data_request_line);
   endproperty
   a_dma_irq: assert property (p_dma_irq) else $error("dma read irq before last byte");
   property p_dma_quiet;
      rd_cmd && cmd_reg[3] && $rose(data_request_line) |-> !interrupt_request_line;
   endproperty
   a_dma_quiet: assert property (p_dma_quiet) else $error("dma read irq with first dreq");
endmodule : dtf_props

// [bench/disk_task_file_command_front_end_test.sv]
/* self-checking bench: host end and device end joined on one task file bus.
   assumes the host end runs one whole command per start pulse, then done. */
`timescale 1ns/1ps
module disk_task_file_command_front_end_test;
   import dtf_pkg::*;
   localparam int SB = 8;
   logic clk_sys, reset, start, wr_byte_take, rd_byte_valid, done, idle, auto_ok;
   logic [7:0] cmd_in, precomp_in, sdh_in, wr_byte, rd_byte, status_seen;
   logic drive_ready, drive_write_fault, drive_seek_done, track_zero_line, media_data_ok;
   logic [9:0] target_cylinder;
   logic [5:0] mev, err_sel;
   logic low_current, pc_en, step_pulse, write_enable;
   logic [3:0] pc_ns;
   logic [7:0] rd_buf [0:15];
   int cyc = 0, n_take = 0, n_rd = 0, n_step = 0, n_wen = 0, gap = 0, last_step = 0;
   int failures = 0, samples_checked = 0;
   dtf_if bus_a ();
   dtf_host dtf_host_inst (.clk_sys(clk_sys), .reset(reset), .bus(bus_a), .start(start),
      .cmd_in(cmd_in), .precomp_in(precomp_in), .sdh_in(sdh_in), .wr_byte(wr_byte),
      .wr_byte_take(wr_byte_take), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
      .status_seen(status_seen), .done(done), .idle(idle));
   dtf_device #(.SECTOR_BYTES(SB), .STEP_MIN_CYC(3), .STEP_UNIT_CYC(5)) dtf_device_inst (
      .clk_sys(clk_sys), .reset(reset), .bus(bus_a), .drive_ready(drive_ready),
      .drive_write_fault(drive_write_fault), .drive_seek_done(drive_seek_done),
      .track_zero_line(track_zero_line), .target_cylinder(target_cylinder),
      .media_id_found(mev[5]), .media_id_missing(mev[2]), .media_id_crc_bad(mev[1]),
      .media_bad_block(mev[0]), .media_mark_seen(1'b0), .media_byte_tick(err_sel[5]),
      .media_data_ok(media_data_ok), .media_data_corrected(mev[4]),
      .media_data_uncorrectable(mev[3]), .reduced_write_current_line(low_current),
      .precomp_enable(pc_en), .precomp_delay_ns(pc_ns), .step_pulse(step_pulse),
      .write_enable(write_enable));
   dtf_props dtf_props_inst (.clk_sys(clk_sys), .reset(reset), .addr(bus_a.addr),
      .rd_strobe(bus_a.rd_strobe), .wr_strobe(bus_a.wr_strobe), .wdata(bus_a.wdata),
      .rdata(bus_a.rdata), .data_request_line(bus_a.data_request_line),
      .interrupt_request_line(bus_a.interrupt_request_line));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (wr_byte_take) n_take <= n_take + 1;
      if (write_enable) n_wen <= n_wen + 1;
      if (rd_byte_valid) begin
         rd_buf[n_rd[3:0]] <= rd_byte;
         n_rd <= n_rd + 1;
      end
      if (step_pulse) begin
         gap <= cyc - last_step;
         last_step <= cyc;
         n_step <= n_step + 1;
      end
      // counts restart with each start pulse
      if (start) {n_take, n_rd, n_wen, n_step} <= '0;
   end
   // media engine stand-in: fault pulse mid-way, completion every 16 cycles
   always @(negedge clk_sys) begin
      wr_byte <= 8'h3C + 8'(n_take);
      media_data_ok <= auto_ok && cyc[3:0] == 4'h0;
      mev <= (cyc[3:0] == 4'h8) ? err_sel : 6'h00;
   end
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task automatic chk_n(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_n
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic run(input logic [7:0] cmd, input logic [7:0] sdh);
      cmd_in = cmd;
      sdh_in = sdh;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      for (int k = 0; k < 20000 && done !== 1'b1; k++) @(negedge clk_sys);
      if (done !== 1'b1) begin
         failures++;
         $display("[ERR] done expected 1 seen %b", done);
         complete_run();
      end
      // status_seen lands one cycle after done
      @(negedge clk_sys);
   endtask : run
   task automatic t_write;
      run(8'h30, 8'h00);
      chk_n("bytes taken", SB, n_take);
      chk_n("write pulses", 1, n_wen);
      chk8("status", 8'h50, status_seen);
      $display("write test done");
   endtask : t_write
   // long read shows four more bytes, only the sector part is known
   task automatic t_read(input logic [7:0] cmd, input logic [7:0] sdh, input int n);
      run(cmd, sdh);
      chk_n("bytes read", n, n_rd);
      for (int i = 0; i < SB; i++) chk8("read byte", 8'h3C + 8'(i), rd_buf[i]);
      chk8("status", 8'h50, status_seen);
      $display("read test done");
   endtask : t_read
   task automatic t_media;
      logic [7:0] exp [0:5] = '{8'h51, 8'h51, 8'h51, 8'h51, 8'h54, 8'h51};
      // completion held off so each fault reaches the engine first
      auto_ok = 1'b0;
      for (int i = 5; i >= 0; i--) begin
         err_sel = 6'h01 << i;
         run(8'h20, 8'h00);
         chk8("status after fault", exp[i], status_seen);
      end
      err_sel = 6'h00;
      auto_ok = 1'b1;
      $display("media fault test done");
   endtask : t_media
   task automatic t_refuse;
      logic [2:0] rws [0:2] = '{3'b001, 3'b111, 3'b100};
      logic [7:0] exp [0:2] = '{8'h11, 8'h71, 8'h41};
      for (int i = 0; i < 3; i++) begin
         {drive_ready, drive_write_fault, drive_seek_done} = rws[i];
         run(8'h20, 8'h00);
         chk8("refused status", exp[i], status_seen);
      end
      {drive_ready, drive_write_fault, drive_seek_done} = 3'b101;
      $display("refusal test done");
   endtask : t_refuse
   // two full 1024-step runs, then one at track zero; cycle counts kept small by the step parameters
   task automatic t_restore;
      auto_ok = 1'b0;
      track_zero_line = 1'b0;
      for (int c = 0; c < 3; c += 2) begin
         run(8'h10 + 8'(c), 8'h00);
         chk_n("steps", 1024, n_step);
         chk_n("step gap", (c == 0) ? 3 : 5 * c, gap);
         chk8("status", 8'h51, status_seen);
      end
      track_zero_line = 1'b1;
      run(8'h10, 8'h00);
      chk8("status cleared", 8'h50, status_seen);
      auto_ok = 1'b1;
      $display("restore test done");
   endtask : t_restore
   task automatic t_precomp;
      target_cylinder = 10'd127;
      repeat (3) @(negedge clk_sys);
      chk8("low current below", 8'h00, {7'h00, low_current});
      target_cylinder = 10'd128;
      repeat (3) @(negedge clk_sys);
      chk8("low current at zone", 8'h01, {7'h00, low_current});
      chk8("precomp ns", 8'h0C, {4'h0, pc_ns});
      $display("precomp test done");
   endtask : t_precomp
   initial begin
      {start, auto_ok, reset} = 3'b011;
      {drive_ready, drive_write_fault, drive_seek_done, track_zero_line} = 4'b1011;
      {cmd_in, sdh_in, precomp_in} = {8'h00, 8'h00, 8'h20};
      {err_sel, target_cylinder} = {6'h00, 10'h000};
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      t_write();
      t_read(8'h20, 8'h00, SB);
      t_read(8'h2A, 8'h80, SB + 4);
      for (int i = 0; i < 2; i++) begin
         run(i ? 8'h50 : 8'h75, 8'h00);
         chk8("status", 8'h50, status_seen);
      end
      t_media();
      t_refuse();
      t_restore();
      t_precomp();
      complete_run();
   end
endmodule : disk_task_file_command_front_end_test
